// *** dv/general_purpose_timer_pair_tb_top.sv ***
`timescale 1ns/10ps
module general_purpose_timer_pair_tb_top;
   logic             clk = 1'b0;
   logic             reset = 1'b1;
   logic [11:0]      addr = 12'h000;
   logic [31:0]      wdata = 32'h0000_0000;
   logic             wr_stb = 1'b0;
   logic             rd_stb = 1'b0;
   logic [31:0]      rdata;
   logic             clk_32k_in;
   logic             master_clock_one_in;
   logic [3:0]       gpio_in;
   logic [1:0][31:0] time_stamp;
   logic [1:0]       count_step;
   logic [1:0]       end_of_count;
   logic [1:0]       timer_status_pin;
   logic [7:0]       eoc_total;
   logic [31:0]      v;
   logic [31:0]      r0;
   logic [31:0]      r1;
   logic             seen;
   int               n;
   int               miscompares = 0;
   int               checks_done = 0;
   int               exp_eoc = 0;
   logic [11:0]      ofs [5] = '{timer_pair_pkg::OFS_CONTROL, timer_pair_pkg::OFS_LIMIT,
                                 timer_pair_pkg::OFS_START_STOP, timer_pair_pkg::OFS_STATUS,
                                 timer_pair_pkg::OFS_READBACK};
   logic [3:0]       srcs [8] = '{4'h8, 4'h0, 4'h1, 4'h4, 4'hC, 4'hD, 4'hE, 4'hF};

   always #20 clk = ~clk;

   timer_pair dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .clk_32k_in(clk_32k_in),
      .master_clock_one_in(master_clock_one_in), .gpio_in(gpio_in), .time_stamp(time_stamp),
      .count_step(count_step), .end_of_count(end_of_count),
      .timer_status_pin(timer_status_pin));

   ref_source_model ref_u (.clk(clk), .end_of_count(end_of_count), .clk_32k_in(clk_32k_in),
      .master_clock_one_in(master_clock_one_in), .gpio_in(gpio_in), .eoc_total(eoc_total));

   task automatic finish_test();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // bounded wait for the next count update; returns the cycles spent
   task automatic wait_step(input int i, output int cyc);
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
         if (cyc > 4000) begin
            miscompares++;
            finish_test();
         end
      end while (count_step[i] !== 1'b1);
   endtask

   function automatic logic [11:0] ba(input int i, input logic [11:0] o);
      return (i != 0 ? timer_pair_pkg::TIMER_STRIDE : 12'h000) + o;
   endfunction

   // sys divisor is 4 for every target code at a 25 MHz clock; divider ignored for code 0
   function automatic int exp_gap(input logic [3:0] src, input int d, input int p);
      int base;
      case (src)
         4'h0: return 4 << p;
         4'h8: base = 4;
         4'h1: base = 8;
         4'h4: base = 10;
         default: base = 12 + 2 * int'(src - 4'hC);
      endcase
      return base << (d + p);
   endfunction

   function automatic logic [31:0] exp_count(input bit up, cont, input int lim, k);
      if (k <= lim)
         return up ? 32'(k) : 32'(lim - k);
      return (up ^ cont) ? 32'(lim) : 32'h0000_0000;
   endfunction

   task automatic run(input int i, input logic [3:0] src, input bit up, cont);
      int          c, gap, d, p, lim;
      logic [31:0] ctl;
      d   = $urandom % 3;
      p   = $urandom % 3;
      lim = 1 + $urandom % 3;
      gap = exp_gap(src, d, p);
      ctl = {10'h000, cont, up, 1'b0, 3'(p), 1'b0, 3'(d), 1'b0, 3'($urandom), 1'b0,
             3'($urandom), src};
      wr(ba(i, ofs[0]), ctl);
      wr(ba(i, ofs[1]), 32'(lim));
      wr(ba(i, ofs[2]), 32'h0000_0001);
      @(negedge clk);
      check(time_stamp[i], exp_count(up, cont, lim, 0));
      check(32'(timer_status_pin[i]), 32'h0000_0001);
      for (int k = 1; k <= lim + 1; k++) begin
         wait_step(i, c);
         if (k > 1)
            check(32'(c), 32'(gap));
         check(time_stamp[i], exp_count(up, cont, lim, k));
         check(32'(end_of_count[i]), 32'(k == lim + 1));
      end
      exp_eoc++;
      check(32'(timer_status_pin[i]), 32'(cont));
      // stop lands two cycles after the end step, before the next one can fall due
      if (cont)
         wr(ba(i, ofs[2]), 32'h0000_0010);
      rd(ba(i, ofs[3]), v);
      check(v, 32'h0000_0000);
      rd(ba(i, ofs[4]), v);
      check(v, exp_count(up, cont, lim, lim + 1));
   endtask

   initial begin
      void'($urandom(32'h0AE83233));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         for (int j = 0; j < 5; j++) begin
            rd(ba(i, ofs[j]), v);
            check(v, 32'h0000_0000);
         end
      end
      wr(12'h0F0, $urandom);
      rd(12'h0F0, v);
      check(v, 32'h0000_0000);
      r0 = $urandom;
      r1 = $urandom;
      wr(ba(0, ofs[0]), r0);
      wr(ba(1, ofs[0]), r1);
      wr(ba(0, ofs[1]), r1);
      wr(ba(1, ofs[1]), r0);
      rd(ba(0, ofs[0]), v);
      check(v, r0 & timer_pair_pkg::CONTROL_MASK);
      rd(ba(1, ofs[0]), v);
      check(v, r1 & timer_pair_pkg::CONTROL_MASK);
      rd(ba(0, ofs[1]), v);
      check(v, r1);
      rd(ba(1, ofs[1]), v);
      check(v, r0);
      for (int k = 0; k < 16; k++) begin
         if (k < 8)
            run(k % 2, srcs[k], k[1], k[2]);
         else
            run($urandom % 2, srcs[k - 8], $urandom % 2, $urandom % 2);
      end
      wr(ba(0, ofs[0]), 32'h0010_0008);
      wr(ba(0, ofs[1]), 32'h0000_0064);
      wr(ba(0, ofs[2]), 32'h0000_0001);
      wait_step(0, n);
      wait_step(0, n);
      wr(ba(0, ofs[2]), 32'h0000_0001);
      @(negedge clk);
      check(time_stamp[0], 32'h0000_0000);
      // largest prescaler, then largest divider, on the system source
      wr(ba(0, ofs[2]), 32'h0000_0010);
      wr(ba(0, ofs[0]), 32'h0017_0008);
      wr(ba(0, ofs[2]), 32'h0000_0001);
      wait_step(0, n);
      wait_step(0, n);
      check(32'(n), 32'(exp_gap(4'h8, 0, 7)));
      wr(ba(0, ofs[2]), 32'h0000_0010);
      wr(ba(0, ofs[0]), 32'h0010_7008);
      wr(ba(0, ofs[2]), 32'h0000_0001);
      wait_step(0, n);
      wait_step(0, n);
      check(32'(n), 32'(exp_gap(4'h8, 7, 0)));
      wr(ba(0, ofs[2]), 32'h0000_0010);
      wr(ba(0, ofs[0]), 32'h0010_0002);
      wr(ba(0, ofs[2]), 32'h0000_0001);
      seen = 1'b0;
      repeat (200) begin
         @(negedge clk);
         seen = seen | count_step[0];
      end
      check(32'(seen), 32'h0000_0000);
      check(32'(timer_status_pin[0]), 32'h0000_0001);
      wr(ba(0, ofs[2]), 32'h0000_0010);
      check(32'(eoc_total), 32'(exp_eoc));
      finish_test();
   end
endmodule

// *** dv/ref_source_model.sv ***
`timescale 1ns/10ps
module ref_source_model (
   // timer side
   input  wire logic       clk,
   input  wire logic [1:0] end_of_count,
   // reference pins
   output logic            clk_32k_in,
   output logic            master_clock_one_in,
   output logic [3:0]      gpio_in,
   // interrupt controller tally
   output logic [7:0]      eoc_total
);
   logic       pin_lvl [6];
   logic [7:0] tally = 8'h00;

   // pin j runs with a period of 8+2j clk cycles, 50% duty, below 12 MHz and clk/3;
   // distinct periods expose a wrong source mapping
   for (genvar j = 0; j < 6; j++) begin : g_pin
      initial begin
         pin_lvl[j] = 1'b0;
         #7;
         forever #((4 + j) * 40) pin_lvl[j] = ~pin_lvl[j];
      end
   end

   assign clk_32k_in          = pin_lvl[0];
   assign master_clock_one_in = pin_lvl[1];
   assign gpio_in             = {pin_lvl[5], pin_lvl[4], pin_lvl[3], pin_lvl[2]};
   assign eoc_total           = tally;

   always @(posedge clk) begin
      tally <= tally + 8'(end_of_count[0]) + 8'(end_of_count[1]);
   end
endmodule

// *** rtl/timer_pair.sv ***
`timescale 1ns/10ps
// Contract
// - two independent timers, index one and two, identical fields each
// - each count value goes out as time stamp and alarm count source
// - reference clock comes from the source chosen by the select field
// - select codes: 0/8 system clock, 1 32 kHz, 4 master clock, C-F GPIO
// - system clock source reduced by target select, ratio computed in hardware
// - target select codes 0-3 give 6.144, 12.288, 24.576, 49.152 MHz
// - reference at or above target unless clock or rate limit prevents it
// - power-of-two reference divider bits 14:12, ignored for code 0
// - prescaler bits 18:16 divides reference 1 to 128, sets count rate
// - limit ends an up count and is the start of a down count
// - live count readable at any time
// - live count and limit are 32 bits wide
// - writing start begins, or restarts, counting from the initial value
// - writing stop halts the timer and clears running
// - control bit 20 picks direction: 0 down, 1 up
// - control bit 21 picks single or continuous, continuous reloads at end
// - read-only running flag is 1 while counting
// - end of count is signalled one count period after the final value
// - each timer's status drives a pin output
module timer_pair (
   // clock and reset
   input  wire logic                                     clk,
   input  wire logic                                     reset,
   // register port
   input  wire logic [timer_pair_pkg::ADDR_W-1:0]        addr,
   input  wire logic [timer_pair_pkg::DATA_W-1:0]        wdata,
   input  wire logic                                     wr_stb,
   input  wire logic                                     rd_stb,
   output logic      [timer_pair_pkg::DATA_W-1:0]        rdata,
   // reference clock pins
   input  wire logic                                     clk_32k_in,
   input  wire logic                                     master_clock_one_in,
   input  wire logic [3:0]                               gpio_in,
   // per-timer outputs to logger, alarms, interrupts and pins
   output logic [1:0][timer_pair_pkg::CNT_W-1:0]         time_stamp,
   output logic [1:0]                                    count_step,
   output logic [1:0]                                    end_of_count,
   output logic [1:0]                                    timer_status_pin
);

   timer_pair_pkg::state_t st;
   timer_pair_pkg::state_t next_st;
   logic [1:0]             step_now;
   logic [1:0]             at_end;

   function automatic logic [timer_pair_pkg::SYSC_W-1:0] sys_divisor(input logic [2:0] sel);
      int target;
      int d;
      case (sel)
         3'h1:    target = timer_pair_pkg::FREQ_SEL1_HZ;
         3'h2:    target = timer_pair_pkg::FREQ_SEL2_HZ;
         3'h3:    target = timer_pair_pkg::FREQ_SEL3_HZ;
         default: target = timer_pair_pkg::FREQ_SEL0_HZ;
      endcase
      // round the ratio down so the reference lands at or above target
      d = timer_pair_pkg::SYS_CLK_HZ / target;
      if (d < timer_pair_pkg::MIN_SYS_DIVISOR) begin
         d = timer_pair_pkg::MIN_SYS_DIVISOR;
      end
      return d[timer_pair_pkg::SYSC_W-1:0];
   endfunction

   function automatic logic [timer_pair_pkg::DIVC_W-1:0] pow2_last(input logic [2:0] code);
      return (8'h01 << code) - 8'h01;
   endfunction

   function automatic logic ext_edge(input logic [3:0] src,
                                     input logic [timer_pair_pkg::EXT_W-1:0] edges);
      case (src)
         timer_pair_pkg::SRC_32K:   return edges[0];
         timer_pair_pkg::SRC_MCLK:  return edges[1];
         timer_pair_pkg::SRC_GPIO1: return edges[2];
         timer_pair_pkg::SRC_GPIO2: return edges[3];
         timer_pair_pkg::SRC_GPIO3: return edges[4];
         timer_pair_pkg::SRC_GPIO4: return edges[5];
         default:                   return 1'b0;
      endcase
   endfunction

   always_comb begin
      logic [timer_pair_pkg::EXT_W-1:0] edges;
      logic [11:0]                      base;
      logic [3:0]                       src;
      logic                             is_sys;
      logic                             sys_tick;
      logic                             ref_tick;
      logic                             div_tick;
      logic                             up;
      edges    = '0;
      base     = '0;
      src      = '0;
      is_sys   = 1'b0;
      sys_tick = 1'b0;
      ref_tick = 1'b0;
      div_tick = 1'b0;
      up       = 1'b0;
      step_now = '0;
      at_end   = '0;
      next_st  = st;
      // pins pass two flops; the third only serves edge detection
      next_st.sync1 = {gpio_in, master_clock_one_in, clk_32k_in};
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      edges         = st.sync2 & ~st.sync3;
      next_st.rdata = '0;
      for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
         base = timer_pair_pkg::TIMER_STRIDE * 12'(i);
         src  = st.tm[i].ctrl[timer_pair_pkg::SRC_LSB +: 4];
         up   = st.tm[i].ctrl[timer_pair_pkg::DIR_BIT];
         next_st.tm[i].step = 1'b0;
         next_st.tm[i].eoc  = 1'b0;
         is_sys = (src == timer_pair_pkg::SRC_CORE) ||
            (src == timer_pair_pkg::SRC_SYS);
         if (src == timer_pair_pkg::SRC_CORE) begin
            sys_tick = st.tm[i].sys_cnt ==
               sys_divisor(st.tm[i].ctrl[timer_pair_pkg::CORE_SEL_LSB +: 3]) - 4'h1;
         end else begin
            sys_tick = st.tm[i].sys_cnt ==
               sys_divisor(st.tm[i].ctrl[timer_pair_pkg::REF_SEL_LSB +: 3]) - 4'h1;
         end
         ref_tick = is_sys ? sys_tick : ext_edge(src, edges);
         if (src == timer_pair_pkg::SRC_CORE) begin
            div_tick = ref_tick;
         end else begin
            div_tick = ref_tick && (st.tm[i].div_cnt ==
               pow2_last(st.tm[i].ctrl[timer_pair_pkg::DIV_LSB +: 3]));
         end
         step_now[i] = (st.tm[i].run == timer_pair_pkg::COUNTING) && div_tick &&
            (st.tm[i].pre_cnt ==
            pow2_last(st.tm[i].ctrl[timer_pair_pkg::PRE_LSB +: 3]));
         at_end[i] = up ? (st.tm[i].count == st.tm[i].limit) :
            (st.tm[i].count == '0);
         if (st.tm[i].run == timer_pair_pkg::COUNTING) begin
            if (is_sys) begin
               next_st.tm[i].sys_cnt = sys_tick ? '0 : st.tm[i].sys_cnt + 4'h1;
            end
            if (ref_tick && src != timer_pair_pkg::SRC_CORE) begin
               next_st.tm[i].div_cnt = div_tick ? '0 : st.tm[i].div_cnt + 8'h01;
            end
            if (div_tick) begin
               next_st.tm[i].pre_cnt = step_now[i] ? '0 : st.tm[i].pre_cnt + 8'h01;
            end
         end
         if (step_now[i]) begin
            next_st.tm[i].step = 1'b1;
            if (at_end[i]) begin
               // final value was reached one step ago; flag it now
               next_st.tm[i].eoc = 1'b1;
               if (st.tm[i].ctrl[timer_pair_pkg::CONT_BIT]) begin
                  next_st.tm[i].count = up ? '0 : st.tm[i].limit;
               end else begin
                  next_st.tm[i].run = timer_pair_pkg::IDLE;
               end
            end else if (up) begin
               next_st.tm[i].count = st.tm[i].count + 32'h0000_0001;
            end else begin
               next_st.tm[i].count = st.tm[i].count - 32'h0000_0001;
            end
         end
         // software writes take priority over the counting step
         if (wr_stb && addr == base + timer_pair_pkg::OFS_CONTROL) begin
            next_st.tm[i].ctrl = wdata & timer_pair_pkg::CONTROL_MASK;
         end else if (wr_stb && addr == base + timer_pair_pkg::OFS_LIMIT) begin
            next_st.tm[i].limit = wdata;
         end else if (wr_stb && addr == base + timer_pair_pkg::OFS_START_STOP) begin
            if (wdata[timer_pair_pkg::START_BIT]) begin
               next_st.tm[i].run     = timer_pair_pkg::COUNTING;
               next_st.tm[i].count   = up ? '0 : st.tm[i].limit;
               next_st.tm[i].sys_cnt = '0;
               next_st.tm[i].div_cnt = '0;
               next_st.tm[i].pre_cnt = '0;
            end else if (wdata[timer_pair_pkg::STOP_BIT]) begin
               next_st.tm[i].run = timer_pair_pkg::IDLE;
            end
         end
         if (rd_stb && addr == base + timer_pair_pkg::OFS_CONTROL) begin
            next_st.rdata = st.tm[i].ctrl;
         end else if (rd_stb && addr == base + timer_pair_pkg::OFS_LIMIT) begin
            next_st.rdata = st.tm[i].limit;
         end else if (rd_stb && addr == base + timer_pair_pkg::OFS_STATUS) begin
            next_st.rdata[timer_pair_pkg::RUN_BIT] = st.tm[i].run;
         end else if (rd_stb && addr == base + timer_pair_pkg::OFS_READBACK) begin
            next_st.rdata = st.tm[i].count;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      rdata = st.rdata;
      for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
         time_stamp[i]       = st.tm[i].count;
         count_step[i]       = st.tm[i].step;
         end_of_count[i]     = st.tm[i].eoc;
         timer_status_pin[i] = st.tm[i].run;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_write(logic [11:0] a);
      wr_stb && addr == a;
   endsequence

   sequence s_read(logic [11:0] a);
      rd_stb && addr == a;
   endsequence

   // read data stand for one cycle only, then fall back to zero
   a_rdata_idle: assert property (
      !rd_stb |=> rdata == '0)
      else $error("read data stood outside its cycle");

   for (genvar g = 0; g < timer_pair_pkg::NUM_TIMERS; g++) begin : g_chk
      localparam logic [11:0] BASE = timer_pair_pkg::TIMER_STRIDE * 12'(g);
      logic       up_g;
      logic       cont_g;
      logic [3:0] src_g;
      logic       fast_sys_g;
      logic       reserved_g;
      assign up_g   = st.tm[g].ctrl[timer_pair_pkg::DIR_BIT];
      assign cont_g = st.tm[g].ctrl[timer_pair_pkg::CONT_BIT];
      assign src_g  = st.tm[g].ctrl[timer_pair_pkg::SRC_LSB +: 4];
      // system source, divider and prescaler at one: one step per system divisor
      assign fast_sys_g = (src_g == timer_pair_pkg::SRC_SYS) &&
         (st.tm[g].ctrl[timer_pair_pkg::DIV_LSB +: 3] == 3'h0) &&
         (st.tm[g].ctrl[timer_pair_pkg::PRE_LSB +: 3] == 3'h0);
      assign reserved_g = !(src_g inside {timer_pair_pkg::SRC_CORE, timer_pair_pkg::SRC_32K,
         timer_pair_pkg::SRC_MCLK, timer_pair_pkg::SRC_SYS, timer_pair_pkg::SRC_GPIO1,
         timer_pair_pkg::SRC_GPIO2, timer_pair_pkg::SRC_GPIO3, timer_pair_pkg::SRC_GPIO4});

      sequence s_end_step;
         step_now[g] && at_end[g] && !wr_stb;
      endsequence

      a_start_loads: assert property (
         s_write(BASE + timer_pair_pkg::OFS_START_STOP) ##0 wdata[timer_pair_pkg::START_BIT]
         |=> timer_status_pin[g] && time_stamp[g] == (up_g ? '0 : st.tm[g].limit))
         else $error("start did not load the initial count");

      a_stop_halts: assert property (
         s_write(BASE + timer_pair_pkg::OFS_START_STOP) ##0
         (wdata[timer_pair_pkg::STOP_BIT] && !wdata[timer_pair_pkg::START_BIT])
         |=> !timer_status_pin[g] ##1 !timer_status_pin[g])
         else $error("stop did not halt the timer");

      a_step_up: assert property (
         step_now[g] && !at_end[g] && up_g && !wr_stb
         |=> count_step[g] && time_stamp[g] == $past(time_stamp[g]) + 32'h0000_0001)
         else $error("up count did not advance by one");

      a_single_end: assert property (
         s_end_step ##0 !cont_g
         |=> end_of_count[g] && !timer_status_pin[g] && time_stamp[g] == $past(time_stamp[g])
         ##1 !end_of_count[g])
         else $error("single mode did not stop at end of count");

      a_cont_reload: assert property (
         s_end_step ##0 cont_g
         |=> end_of_count[g] && timer_status_pin[g] &&
         time_stamp[g] == (up_g ? '0 : st.tm[g].limit))
         else $error("continuous mode did not reload");

      a_eoc_cause: assert property (
         end_of_count[g] |-> $past(step_now[g] && at_end[g]))
         else $error("end of count without a due step at the final value");

      a_status_read: assert property (
         s_read(BASE + timer_pair_pkg::OFS_STATUS)
         |=> rdata == {31'h0, $past(timer_status_pin[g])})
         else $error("status read does not show running state");

      a_count_read: assert property (
         s_read(BASE + timer_pair_pkg::OFS_READBACK) |=> rdata == $past(time_stamp[g]))
         else $error("readback differs from live count");

      a_prescale_gap: assert property (
         count_step[g] && st.tm[g].ctrl[timer_pair_pkg::PRE_LSB +: 3] == 3'h7 && !wr_stb
         |=> !count_step[g] [*8])
         else $error("prescale by 128 stepped too soon");

      a_step_down: assert property (
         step_now[g] && !at_end[g] && !up_g && !wr_stb
         |=> count_step[g] && time_stamp[g] == $past(time_stamp[g]) - 32'h0000_0001)
         else $error("down count did not fall by one");

      a_step_spacing: assert property (
         count_step[g] |=> !count_step[g])
         else $error("count stepped in two cycles running");

      // four clocks is the system divisor for every target at this clock rate
      a_sys_rate: assert property (
         count_step[g] && timer_status_pin[g] && fast_sys_g && !wr_stb ##1 !wr_stb [*3]
         |=> count_step[g])
         else $error("system reference ran slower than its target");

      a_reserved_idle: assert property (
         reserved_g |=> !count_step[g])
         else $error("reserved source code produced a count step");

      a_halt_freeze: assert property (
         !timer_status_pin[g] && !wr_stb |=> !count_step[g] && $stable(time_stamp[g]))
         else $error("stopped timer kept counting");

      a_ctrl_write: assert property (
         s_write(BASE + timer_pair_pkg::OFS_CONTROL)
         |=> st.tm[g].ctrl == ($past(wdata) & timer_pair_pkg::CONTROL_MASK))
         else $error("control write not stored in its own timer");

      a_ctrl_read: assert property (
         s_read(BASE + timer_pair_pkg::OFS_CONTROL) |=> rdata == $past(st.tm[g].ctrl))
         else $error("control read differs from stored control");

      a_limit_write: assert property (
         s_write(BASE + timer_pair_pkg::OFS_LIMIT) |=> st.tm[g].limit == $past(wdata))
         else $error("limit write not stored in full");

      a_limit_read: assert property (
         s_read(BASE + timer_pair_pkg::OFS_LIMIT) |=> rdata == $past(st.tm[g].limit))
         else $error("limit read differs from stored limit");

      a_cmd_read_zero: assert property (
         s_read(BASE + timer_pair_pkg::OFS_START_STOP) |=> rdata == '0)
         else $error("start and stop controls did not read zero");

      a_eoc_at_step: assert property (
         end_of_count[g] |-> count_step[g])
         else $error("end of count outside a count update");
   end

endmodule

// *** rtl/timer_pair_pkg.sv ***
package timer_pair_pkg;

   // geometry
   localparam int          NUM_TIMERS = 2;
   localparam int          ADDR_W     = 12;
   localparam int          DATA_W     = 32;
   localparam int          CNT_W      = 32;
   localparam int          DIVC_W     = 8;
   localparam int          SYSC_W     = 4;
   localparam int          EXT_W      = 6;

   // register map, per timer at base + offset
   localparam logic [11:0] TIMER_STRIDE   = 12'h100;
   localparam logic [11:0] OFS_CONTROL    = 12'h000;
   localparam logic [11:0] OFS_LIMIT      = 12'h004;
   localparam logic [11:0] OFS_START_STOP = 12'h00C;
   localparam logic [11:0] OFS_STATUS     = 12'h010;
   localparam logic [11:0] OFS_READBACK   = 12'h014;

   // timer_control field positions
   localparam int          SRC_LSB      = 0;
   localparam int          CORE_SEL_LSB = 4;
   localparam int          REF_SEL_LSB  = 8;
   localparam int          DIV_LSB      = 12;
   localparam int          PRE_LSB      = 16;
   localparam int          DIR_BIT      = 20;
   localparam int          CONT_BIT     = 21;
   localparam logic [31:0] CONTROL_MASK = 32'h0037_777F;
   localparam int          START_BIT    = 0;
   localparam int          STOP_BIT     = 4;
   localparam int          RUN_BIT      = 0;

   // reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RESET   = 32'h0000_0000;
   localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;

   // reference source codes
   typedef enum logic [3:0] {
      SRC_CORE  = 4'h0,
      SRC_32K   = 4'h1,
      SRC_MCLK  = 4'h4,
      SRC_SYS   = 4'h8,
      SRC_GPIO1 = 4'hC,
      SRC_GPIO2 = 4'hD,
      SRC_GPIO3 = 4'hE,
      SRC_GPIO4 = 4'hF
   } ref_source_t;

   typedef enum logic {
      IDLE     = 1'b0,
      COUNTING = 1'b1
   } timer_state_t;

   // clocking figures
   localparam int SYS_CLK_HZ      = 25_000_000;
   localparam int MAX_REF_HZ      = 12_000_000;
   localparam int SYS_RATIO_LIMIT = 3;
   localparam int FREQ_SEL0_HZ    = 6_144_000;
   localparam int FREQ_SEL1_HZ    = 12_288_000;
   localparam int FREQ_SEL2_HZ    = 24_576_000;
   localparam int FREQ_SEL3_HZ    = 49_152_000;
   // reference must stay strictly below both limits, hence the +1
   localparam int MIN_SYS_DIVISOR =
      (SYS_CLK_HZ / MAX_REF_HZ > SYS_RATIO_LIMIT) ?
      SYS_CLK_HZ / MAX_REF_HZ + 1 : SYS_RATIO_LIMIT + 1;

   typedef struct packed {
      timer_state_t        run;
      logic [31:0]         ctrl;
      logic [CNT_W-1:0]    limit;
      logic [CNT_W-1:0]    count;
      logic [SYSC_W-1:0]   sys_cnt;
      logic [DIVC_W-1:0]   div_cnt;
      logic [DIVC_W-1:0]   pre_cnt;
      logic                step;
      logic                eoc;
   } timer_t;

   typedef struct packed {
      logic [EXT_W-1:0]    sync1;
      logic [EXT_W-1:0]    sync2;
      logic [EXT_W-1:0]    sync3;
      logic [DATA_W-1:0]   rdata;
      timer_t [NUM_TIMERS-1:0] tm;
   } state_t;

endpackage
